// File: rtl/bsc_pkg.sv
// Shared constants and types for the secondary-side strap configuration block.
// How it works
// - With capability strap high, max-frequency strap picks 100 (one) or 133 (zero) pattern.
// - Max-frequency strap is ignored in conventional PCI mode.
// - Conventional PCI mode bypasses the PLL and uses the bus clock directly.
// - Private device mask resets to zero, or to the hiding pattern when reroute strap set.
// - Reroute set hides private-space select lines; cleared hides nothing.
// - Arbiter strap high arbitrates internally; low defers to an external arbiter.
// - Two clock switches select 133, 100, 66 or 33 MHz.
// - Clock circuit switch off drives the secondary clock; on disables it.
// - Isolation switch on connects the network controller; off isolates it.
`default_nettype none
package bsc_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NREQ   = 4;

  localparam logic [ADDR_W-1:0] ADDR_MASK   = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;

  localparam logic [DATA_W-1:0] MASK_NONE = 32'h00000000;
  localparam logic [DATA_W-1:0] MASK_HIDE = 32'h22F20000;

  // Bridge strap vector positions.
  localparam int unsigned BR_W       = 4;
  localparam int unsigned BR_CAP     = 0;
  localparam int unsigned BR_SEL100  = 1;
  localparam int unsigned BR_REROUTE = 2;
  localparam int unsigned BR_ARB     = 3;

  // Board switch vector positions; a one means the switch is on.
  localparam int unsigned BD_W      = 4;
  localparam int unsigned BD_CLK0   = 0;
  localparam int unsigned BD_CLK1   = 1;
  localparam int unsigned BD_CLKOFF = 2;
  localparam int unsigned BD_NIC    = 3;

  // Status word field positions.
  localparam int unsigned ST_BR_LO  = 0;
  localparam int unsigned ST_BD_LO  = 4;
  localparam int unsigned ST_DONE   = 8;
  localparam int unsigned ST_PLLBYP = 9;
  localparam int unsigned ST_GNT_LO = 12;
  localparam int unsigned ST_PAT_LO = 16;
  localparam int unsigned ST_FRQ_LO = 24;

  localparam logic [7:0] FREQ_133 = 8'h85;
  localparam logic [7:0] FREQ_100 = 8'h64;
  localparam logic [7:0] FREQ_66  = 8'h42;
  localparam logic [7:0] FREQ_33  = 8'h21;

  typedef enum logic [2:0] {
    BSC_PH_WAIT = 3'b001,
    BSC_PH_LOAD = 3'b010,
    BSC_PH_RUN  = 3'b100
  } bsc_phase_t;

  typedef enum logic [2:0] {
    BSC_PAT_PCI     = 3'b001,
    BSC_PAT_PCIX100 = 3'b010,
    BSC_PAT_PCIX133 = 3'b100
  } bsc_pattern_t;

endpackage
`default_nettype wire

// File: rtl/bsc_cfg_if.sv
// Link between the configuration core and its register slave.
`timescale 1ns/100ps
`default_nettype none
interface bsc_cfg_if;
  import bsc_pkg::*;
  logic              maskLoad;
  logic [DATA_W-1:0] maskInit;
  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] mask;

  modport core (output maskLoad, output maskInit, output status, input mask);
  modport regs (input maskLoad, input maskInit, input status, output mask);
endinterface
`default_nettype wire

// File: rtl/bsc_strap_latch.sv
// Capture register that holds a strap vector from reset release to the next reset.
`timescale 1ns/100ps
`default_nettype none
module bsc_strap_latch
  import bsc_pkg::*;
#(
  parameter int unsigned W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         capture,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] q;
  } bsc_latch_t;

  bsc_latch_t state;
  bsc_latch_t next_state;

  // Reset forces a constant; the strap level is taken only by the clocked capture.
  always_comb begin
    next_state = state;
    if (capture) begin
      next_state.q = d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign q = state.q;
endmodule
`default_nettype wire

// File: rtl/bsc_apb_regs.sv
// APB slave holding the private device mask and the read-only status word.
`timescale 1ns/100ps
`default_nettype none
module bsc_apb_regs
  import bsc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  bsc_cfg_if.regs                cfg
);
  typedef struct packed {
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] rdata;
    logic              err;
  } bsc_regs_t;

  bsc_regs_t state;
  bsc_regs_t next_state;
  logic      setup;
  logic      access;
  logic      mapped;

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == ADDR_MASK) || (paddr == ADDR_STATUS);

  // Read data and error are settled in the setup cycle so that the access
  // phase can complete with no wait state.
  always_comb begin
    next_state = state;
    if (setup) begin
      next_state.err   = !mapped || (pwrite && paddr == ADDR_STATUS);
      next_state.rdata = MASK_NONE;
      if (!pwrite && paddr == ADDR_MASK) begin
        next_state.rdata = state.mask;
      end
      if (!pwrite && paddr == ADDR_STATUS) begin
        next_state.rdata = cfg.status;
      end
    end
    if (access && pwrite && paddr == ADDR_MASK) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          next_state.mask[b*8 +: 8] = pwdata[b*8 +: 8];
        end
      end
    end
    // The strap-derived value lands once after reset and wins over any write.
    if (cfg.maskLoad) begin
      next_state.mask = cfg.maskInit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign cfg.mask = state.mask;
  assign prdata   = state.rdata;
  assign pslverr  = state.err && access;
  assign pready   = 1'b1;
endmodule
`default_nettype wire

// File: rtl/bsc_bridge_strap_config.sv
// Top of the strap configuration block: capture, mode decode, hiding and arbitration.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module bsc_bridge_strap_config
  import bsc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  // APB register port.
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Bridge straps, sampled as levels.
  input  wire logic              secondaryCapabilityStrap,
  input  wire logic              maxFreqSelect,
  input  wire logic              hideRerouteEnable,
  input  wire logic              internalArbiterEnable,
  // Board switches, one meaning on.
  input  wire logic [1:0]        secClkCfgSwitch,
  input  wire logic              secClkCircuitSwitch,
  input  wire logic              nicIsolationSwitch,
  // Configuration select lines of the secondary bus.
  input  wire logic [DATA_W-1:0] cfgIdsel,
  output logic      [DATA_W-1:0] idselOut,
  output logic                   deviceHidden,
  // Secondary bus arbitration.
  input  wire logic [NREQ-1:0]   busReq,
  output logic      [NREQ-1:0]   busGnt,
  output logic                   extArbiterSelect,
  // Decoded operating mode.
  output logic                   pllBypass,
  output logic      [2:0]        initPattern,
  output logic                   initPatternValid,
  output logic      [1:0]        secClkSel,
  output logic      [7:0]        secClkFreqMhz,
  output logic                   secClkOutEn,
  output logic                   nicConnect,
  output logic                   configDone
);

  typedef struct packed {
    bsc_phase_t        phase;
    bsc_pattern_t      pattern;
    logic              patValid;
    logic              pllBypass;
    logic [1:0]        clkSel;
    logic [7:0]        freq;
    logic              clkOutEn;
    logic              nicConnect;
    logic              extArb;
    logic [NREQ-1:0]   gnt;
    logic [1:0]        ptr;
    logic [DATA_W-1:0] idsel;
    logic              hidden;
  } bsc_core_t;

  bsc_core_t       state;
  bsc_core_t       next_state;
  logic            capture;
  logic [BR_W-1:0] brStrap;
  logic [BD_W-1:0] bdStrap;
  logic [BR_W-1:0] brLevel;
  logic [BD_W-1:0] bdLevel;

  bsc_cfg_if cfg ();

  assign capture = (state.phase == BSC_PH_WAIT);

  assign brLevel = {internalArbiterEnable, hideRerouteEnable,
                    maxFreqSelect, secondaryCapabilityStrap};
  assign bdLevel = {nicIsolationSwitch, secClkCircuitSwitch, secClkCfgSwitch};

  bsc_strap_latch #(
    .W (BR_W)
  ) uBridgeStraps (
    .clk     (clk),
    .rst     (rst),
    .capture (capture),
    .d       (brLevel),
    .q       (brStrap)
  );

  bsc_strap_latch #(
    .W (BD_W)
  ) uBoardStraps (
    .clk     (clk),
    .rst     (rst),
    .capture (capture),
    .d       (bdLevel),
    .q       (bdStrap)
  );

  bsc_apb_regs uRegs (
    .clk     (clk),
    .rst     (rst),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .cfg     (cfg)
  );

  // The mask initial value follows the captured reroute strap, one cycle after capture.
  assign cfg.maskLoad = (state.phase == BSC_PH_LOAD);
  assign cfg.maskInit = brStrap[BR_REROUTE] ? MASK_HIDE : MASK_NONE;

  always_comb begin
    cfg.status = '0;
    cfg.status[ST_BR_LO +: BR_W]  = brStrap;
    cfg.status[ST_BD_LO +: BD_W]  = bdStrap;
    cfg.status[ST_DONE]           = (state.phase == BSC_PH_RUN);
    cfg.status[ST_PLLBYP]         = state.pllBypass;
    cfg.status[ST_GNT_LO +: NREQ] = state.gnt;
    cfg.status[ST_PAT_LO +: 3]    = state.pattern;
    cfg.status[ST_FRQ_LO +: 8]    = state.freq;
  end

  always_comb begin
    logic [1:0] idx;
    logic       found;
    logic       arbOn;
    idx        = '0;
    found      = 1'b0;
    arbOn      = 1'b0;
    next_state = state;

    unique case (state.phase)
      BSC_PH_WAIT: begin
        next_state.phase = BSC_PH_LOAD;
      end
      BSC_PH_LOAD: begin
        next_state.phase = BSC_PH_RUN;
      end
      BSC_PH_RUN: begin
        next_state.phase = BSC_PH_RUN;
      end
      default: begin
        next_state.phase = BSC_PH_WAIT;
      end
    endcase

    // Decode runs from the held straps only, so live switch motion has no effect.
    if (state.phase != BSC_PH_WAIT) begin
      next_state.patValid = 1'b1;
      if (brStrap[BR_CAP]) begin
        next_state.pllBypass = 1'b0;
        if (brStrap[BR_SEL100]) begin
          next_state.pattern = BSC_PAT_PCIX100;
        end else begin
          next_state.pattern = BSC_PAT_PCIX133;
        end
      end else begin
        // Conventional mode takes the bus clock straight through; the
        // frequency strap carries no meaning here and no 66/33 split is made.
        next_state.pattern   = BSC_PAT_PCI;
        next_state.pllBypass = 1'b1;
      end

      next_state.clkSel = bdStrap[BD_CLK1:BD_CLK0];
      unique case (bdStrap[BD_CLK1:BD_CLK0])
        2'h0: next_state.freq = FREQ_133;
        2'h1: next_state.freq = FREQ_100;
        2'h2: next_state.freq = FREQ_66;
        2'h3: next_state.freq = FREQ_33;
      endcase
      next_state.clkOutEn   = !bdStrap[BD_CLKOFF];
      next_state.nicConnect = bdStrap[BD_NIC];
      next_state.extArb     = !brStrap[BR_ARB];
    end

    // Hiding masks select lines against the software-visible mask; the
    // answer lags the request by one clock.
    next_state.idsel  = cfgIdsel & ~cfg.mask;
    next_state.hidden = |(cfgIdsel & cfg.mask);

    // Round-robin arbiter: the holder keeps the bus while it requests,
    // otherwise the search starts just past the last winner.
    arbOn = (state.phase == BSC_PH_RUN) && brStrap[BR_ARB];
    if (!arbOn) begin
      next_state.gnt = '0;
    end else if (!(|(state.gnt & busReq))) begin
      next_state.gnt = '0;
      for (int i = 0; i < NREQ; i++) begin
        idx = state.ptr + 2'(i + 1);
        if (!found && busReq[idx]) begin
          found               = 1'b1;
          next_state.gnt[idx] = 1'b1;
          next_state.ptr      = idx;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state            <= '0;
      state.phase      <= BSC_PH_WAIT;
      state.pattern    <= BSC_PAT_PCI;
      state.pllBypass  <= 1'b1;
      state.freq       <= FREQ_133;
    end else begin
      state <= next_state;
    end
  end

  assign idselOut         = state.idsel;
  assign deviceHidden     = state.hidden;
  assign busGnt           = state.gnt;
  assign extArbiterSelect = state.extArb;
  assign pllBypass        = state.pllBypass;
  assign initPattern      = state.pattern;
  assign initPatternValid = state.patValid;
  assign secClkSel        = state.clkSel;
  assign secClkFreqMhz    = state.freq;
  assign secClkOutEn      = state.clkOutEn;
  assign nicConnect       = state.nicConnect;
  assign configDone       = (state.phase == BSC_PH_RUN);

endmodule
`default_nettype wire

// File: testbench/bsc_bridge_strap_config_sva.sv
// Assertion checker for the strap configuration block.
`timescale 1ns/100ps
`default_nettype none
module bsc_bridge_strap_config_sva
  import bsc_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              secondaryCapabilityStrap,
  input wire logic              maxFreqSelect,
  input wire logic              hideRerouteEnable,
  input wire logic              internalArbiterEnable,
  input wire logic [1:0]        secClkCfgSwitch,
  input wire logic              secClkCircuitSwitch,
  input wire logic              nicIsolationSwitch,
  input wire logic [DATA_W-1:0] cfgIdsel,
  input wire logic [DATA_W-1:0] idselOut,
  input wire logic              deviceHidden,
  input wire logic [NREQ-1:0]   busReq,
  input wire logic [NREQ-1:0]   busGnt,
  input wire logic              extArbiterSelect,
  input wire logic              pllBypass,
  input wire logic [2:0]        initPattern,
  input wire logic [7:0]        secClkFreqMhz,
  input wire logic              secClkOutEn,
  input wire logic              nicConnect,
  input wire logic              configDone
);
  localparam logic [7:0] FQ [4] = '{FREQ_133, FREQ_100, FREQ_66, FREQ_33};
  logic [1:0] age;
  logic [7:0] cap;
  // The checker keeps its own copy of the straps, so a design that resamples them is caught.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      age <= 2'h0;
      cap <= 8'h00;
    end else begin
      if (age == 2'h0) cap <= {secondaryCapabilityStrap, maxFreqSelect, hideRerouteEnable,
        internalArbiterEnable, secClkCfgSwitch, secClkCircuitSwitch, nicIsolationSwitch};
      if (age != 2'h3) age <= age + 2'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence sIdleReq;
    configDone && cap[4] && busGnt == 4'h0 && busReq != 4'h0;
  endsequence
  sequence sLoaded;
    $rose(configDone);
  endsequence
  AST_DONE: assert property (configDone == (age >= 2'h2))
    else $error("configuration done at the wrong cycle");
  AST_PATTERN: assert property (configDone |->
    initPattern == (cap[7] ? (cap[6] ? 3'h2 : 3'h4) : 3'h1))
    else $error("init pattern wrong");
  AST_PLL: assert property (configDone |-> pllBypass == !cap[7])
    else $error("pll bypass wrong");
  AST_FREQ: assert property (configDone |-> secClkFreqMhz == FQ[cap[3:2]])
    else $error("clock frequency wrong");
  AST_SWITCH: assert property (configDone |->
    secClkOutEn != cap[1] && nicConnect == cap[0])
    else $error("clock output or nic wrong");
  AST_EXT: assert property (configDone |->
    extArbiterSelect == !cap[4] && (cap[4] || busGnt == 4'h0))
    else $error("arbiter selection wrong");
  AST_GNT_SRC: assert property (busGnt != 4'h0 |->
    $onehot(busGnt) && (busGnt & ~$past(busReq)) == 4'h0)
    else $error("grant to a non requester");
  AST_GRANT: assert property (sIdleReq |=> busGnt != 4'h0)
    else $error("request not granted");
  AST_MASK_LOAD: assert property (sLoaded |=>
    idselOut == ($past(cfgIdsel) & ~(cap[5] ? MASK_HIDE : MASK_NONE)))
    else $error("mask reset value wrong");
  AST_HIDDEN: assert property (configDone |->
    deviceHidden == (idselOut != $past(cfgIdsel)))
    else $error("hidden flag wrong");
endmodule
bind bsc_bridge_strap_config bsc_bridge_strap_config_sva sva (
  .clk                      (clk),
  .rst                      (rst),
  .secondaryCapabilityStrap (secondaryCapabilityStrap),
  .maxFreqSelect            (maxFreqSelect),
  .hideRerouteEnable        (hideRerouteEnable),
  .internalArbiterEnable    (internalArbiterEnable),
  .secClkCfgSwitch          (secClkCfgSwitch),
  .secClkCircuitSwitch      (secClkCircuitSwitch),
  .nicIsolationSwitch       (nicIsolationSwitch),
  .cfgIdsel                 (cfgIdsel),
  .idselOut                 (idselOut),
  .deviceHidden             (deviceHidden),
  .busReq                   (busReq),
  .busGnt                   (busGnt),
  .extArbiterSelect         (extArbiterSelect),
  .pllBypass                (pllBypass),
  .initPattern              (initPattern),
  .secClkFreqMhz            (secClkFreqMhz),
  .secClkOutEn              (secClkOutEn),
  .nicConnect               (nicConnect),
  .configDone               (configDone)
);
`default_nettype wire

// File: testbench/bsc_bus_agents.sv
// Behavioural model of the agents requesting the secondary bus.
`timescale 1ns/100ps
`default_nettype none
module bsc_bus_agents
  import bsc_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic [NREQ-1:0] want,
  input  wire logic [NREQ-1:0] busGnt,
  output logic      [NREQ-1:0] busReq
);
  // Each agent does single transfers: it lets go once granted and asks again later.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busReq <= 4'h0;
    end else begin
      busReq <= (busReq & ~busGnt) | (want & ~busReq);
    end
  end
endmodule
`default_nettype wire

// File: testbench/bsc_bridge_strap_config_test.sv
// Self-checking bench for the strap configuration block.
`timescale 1ns/100ps
`default_nettype none
module bsc_bridge_strap_config_test;
  import bsc_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cfgIdsel, idselOut, rd, st;
  logic [3:0]  pstrb, busReq, busGnt, want;
  logic        secondaryCapabilityStrap, maxFreqSelect, hideRerouteEnable;
  logic        internalArbiterEnable, secClkCircuitSwitch, nicIsolationSwitch;
  logic [1:0]  secClkCfgSwitch, secClkSel;
  logic        deviceHidden, extArbiterSelect, pllBypass, initPatternValid;
  logic        secClkOutEn, nicConnect, configDone;
  logic [2:0]  initPattern;
  logic [7:0]  secClkFreqMhz;
  logic [18:0] r;
  int          errTotal = 0;
  int          checks = 0;
  // Row: straps {cap,sel,reroute,arb,clk[1:0],clkoff,nic}, pattern, frequency.
  logic [18:0] rows [4] = '{{8'hD1, 3'h2, 8'h85}, {8'hA6, 3'h4, 8'h64},
                            {8'h79, 3'h1, 8'h42}, {8'h1E, 3'h1, 8'h21}};
  bsc_bridge_strap_config uut (
    .clk                      (clk),
    .rst                      (rst),
    .paddr                    (paddr),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .pwdata                   (pwdata),
    .pstrb                    (pstrb),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .secondaryCapabilityStrap (secondaryCapabilityStrap),
    .maxFreqSelect            (maxFreqSelect),
    .hideRerouteEnable        (hideRerouteEnable),
    .internalArbiterEnable    (internalArbiterEnable),
    .secClkCfgSwitch          (secClkCfgSwitch),
    .secClkCircuitSwitch      (secClkCircuitSwitch),
    .nicIsolationSwitch       (nicIsolationSwitch),
    .cfgIdsel                 (cfgIdsel),
    .idselOut                 (idselOut),
    .deviceHidden             (deviceHidden),
    .busReq                   (busReq),
    .busGnt                   (busGnt),
    .extArbiterSelect         (extArbiterSelect),
    .pllBypass                (pllBypass),
    .initPattern              (initPattern),
    .initPatternValid         (initPatternValid),
    .secClkSel                (secClkSel),
    .secClkFreqMhz            (secClkFreqMhz),
    .secClkOutEn              (secClkOutEn),
    .nicConnect               (nicConnect),
    .configDone               (configDone)
  );
  bsc_bus_agents agents (
    .clk    (clk),
    .rst    (rst),
    .want   (want),
    .busGnt (busGnt),
    .busReq (busReq)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, cfgIdsel, want} = '0;
    pstrb = 4'hF;
    {secondaryCapabilityStrap, maxFreqSelect, hideRerouteEnable, internalArbiterEnable,
      secClkCfgSwitch, secClkCircuitSwitch, nicIsolationSwitch} = 8'h00;
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      want <= 4'h0;
      rst <= 1'b1;
      {secondaryCapabilityStrap, maxFreqSelect, hideRerouteEnable, internalArbiterEnable,
        secClkCfgSwitch, secClkCircuitSwitch, nicIsolationSwitch} <= r[18:11];
      repeat (2) @(posedge clk);
      chk(configDone, 1'b0);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk(initPattern, r[10:8]);
      chk(secClkFreqMhz, r[7:0]);
      chk(pllBypass, !r[18]);
      chk(secClkOutEn, !r[12]);
      chk(nicConnect, r[11]);
      chk(extArbiterSelect, !r[15]);
      chk(initPatternValid, 1'b1);
      chk(secClkSel, r[14:13]);
      chk(configDone, 1'b1);
      apb(1'b0, ADDR_MASK, 32'h0);
      chk(rd, r[16] ? 32'h22F20000 : 32'h0);
      // Status word: frequency, pattern, idle grant, bypass, done, board and bridge straps.
      st = {r[7:0], 5'h00, r[10:8], 6'h00, !r[18], 1'b1, r[11], r[12], r[14:13],
            r[15], r[16], r[17], r[18]};
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, st);
      // Flip every switch; the decoded mode must not follow.
      {secondaryCapabilityStrap, maxFreqSelect, hideRerouteEnable, internalArbiterEnable,
        secClkCfgSwitch, secClkCircuitSwitch, nicIsolationSwitch} <= ~r[18:11];
      cfgIdsel <= 32'hFFFFFFFF;
      want <= 4'h5;
      repeat (4) @(posedge clk);
      chk(deviceHidden, r[16]);
      chk(idselOut, r[16] ? 32'hDD0DFFFF : 32'hFFFFFFFF);
      chk(busGnt != 4'h0, r[15]);
      chk(initPattern, r[10:8]);
      chk(secClkFreqMhz, r[7:0]);
      $display("strap row %0d finished", i);
    end
    apb(1'b1, ADDR_MASK, 32'h000000F0);
    chk(err, 1'b0);
    apb(1'b0, ADDR_MASK, 32'h0);
    chk(rd, 32'h000000F0);
    repeat (2) @(posedge clk);
    chk(idselOut, 32'hFFFFFF0F);
    chk(deviceHidden, 1'b1);
    // A single byte lane must change only its own byte of the mask.
    pstrb <= 4'h2;
    apb(1'b1, ADDR_MASK, 32'h12345578);
    pstrb <= 4'hF;
    apb(1'b0, ADDR_MASK, 32'h0);
    chk(rd, 32'h000055F0);
    apb(1'b0, 12'h008, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
    chk(err, 1'b1);
    $display("register tests finished");
    wrap_up;
  end
  initial begin
    repeat (2000) @(posedge clk);
    errTotal++;
    wrap_up;
  end
endmodule
`default_nettype wire
